// ===== rtl/npp_partner_page.sv
// Purpose: partner next-page word register behind an AXI4-Lite slave
// Assumes: page strobes come from auto-negotiation logic on sys_clk
// Notes: one write and one read under way at most
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ns
module npp_partner_page (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic base_valid,
  input wire logic base_toggle,
  input wire logic page_valid,
  input wire npp_pkg::npp_word_t page_word,
  output logic irq,
  input wire npp_pkg::npp_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire npp_pkg::npp_data_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output npp_pkg::npp_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire npp_pkg::npp_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output npp_pkg::npp_data_t s_axi_rdata,
  output npp_pkg::npp_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import npp_pkg::*;

  // ==========
  // Address decode
  function automatic logic npp_mapped(input npp_addr_t a);
    npp_mapped = (a == NPP_OFS_STATUS) || (a == NPP_OFS_MASK) ||
      (a == NPP_OFS_WORD) || (a == NPP_OFS_CTRL) ||
      (a == NPP_OFS_INFO);
  endfunction : npp_mapped

  // ==========
  // State
  typedef struct packed {
    npp_wst_e wst;
    npp_addr_t awaddr;
    npp_data_t wdata;
    logic [3:0] wstrb;
    npp_resp_t bresp;
    logic rvalid;
    npp_resp_t rresp;
    npp_data_t rdata;
    logic capture_en;
  } npp_top_s;

  npp_top_s top_reg;
  npp_top_s top_next;

  npp_word_t word_q;
  logic exp_toggle;
  logic active;
  logic [NPP_EV_W-1:0] events;
  logic [NPP_EV_W-1:0] status;
  logic [NPP_EV_W-1:0] mask;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_do;
  npp_addr_t wr_addr;
  npp_data_t wr_data;
  logic [3:0] wr_strb;
  logic mask_we;
  logic status_rd;

  // ==========
  // Sub-blocks
  npp_page_capture u_capture (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .capture_en(top_reg.capture_en),
    .base_valid(base_valid),
    .base_toggle(base_toggle),
    .page_valid(page_valid),
    .page_word(page_word),
    .word_q(word_q),
    .exp_toggle(exp_toggle),
    .active(active),
    .events(events)
  );

  npp_irq u_irq (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .set_ev(events),
    .rd_clr(status_rd),
    .mask_we(mask_we),
    .mask_wdata(wr_data[NPP_EV_W-1:0]),
    .status(status),
    .mask(mask),
    .irq(irq)
  );

  // ==========
  // Handshakes
  // Ready drops with ce so nothing is taken while frozen
  always_comb begin
    s_axi_awready = ce && ((top_reg.wst == NPP_WS_IDLE) ||
      (top_reg.wst == NPP_WS_HAVE_W));
    s_axi_wready = ce && ((top_reg.wst == NPP_WS_IDLE) ||
      (top_reg.wst == NPP_WS_HAVE_AW));
    s_axi_bvalid = (top_reg.wst == NPP_WS_RESP);
    s_axi_arready = ce && !top_reg.rvalid;
  end

  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign status_rd = ar_hs && (s_axi_araddr == NPP_OFS_STATUS);

  // Write is done once both address and data are held
  always_comb begin
    wr_addr = aw_hs ? s_axi_awaddr : top_reg.awaddr;
    wr_data = w_hs ? s_axi_wdata : top_reg.wdata;
    wr_strb = w_hs ? s_axi_wstrb : top_reg.wstrb;
    case (top_reg.wst)
      NPP_WS_IDLE: wr_do = aw_hs && w_hs;
      NPP_WS_HAVE_AW: wr_do = w_hs;
      NPP_WS_HAVE_W: wr_do = aw_hs;
      default: wr_do = 1'b0;
    endcase
    mask_we = wr_do && (wr_addr == NPP_OFS_MASK) && wr_strb[0];
  end

  // ==========
  // Next state
  always_comb begin
    top_next = top_reg;
    case (top_reg.wst)
      NPP_WS_IDLE: begin
        if (aw_hs && !w_hs) begin
          top_next.wst = NPP_WS_HAVE_AW;
        end else if (w_hs && !aw_hs) begin
          top_next.wst = NPP_WS_HAVE_W;
        end
      end
      NPP_WS_HAVE_AW: begin
        if (w_hs) begin
          top_next.wst = NPP_WS_RESP;
        end
      end
      NPP_WS_HAVE_W: begin
        if (aw_hs) begin
          top_next.wst = NPP_WS_RESP;
        end
      end
      NPP_WS_RESP: begin
        if (s_axi_bready) begin
          top_next.wst = NPP_WS_IDLE;
        end
      end
      default: top_next.wst = NPP_WS_IDLE;
    endcase
    if (aw_hs) begin
      top_next.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      top_next.wdata = s_axi_wdata;
      top_next.wstrb = s_axi_wstrb;
    end
    if (wr_do) begin
      top_next.wst = NPP_WS_RESP;
      top_next.bresp = npp_mapped(wr_addr) ? NPP_RESP_OKAY :
        NPP_RESP_SLVERR;
      // Word, status and info are read-only: write is answered, dropped
      if ((wr_addr == NPP_OFS_CTRL) && wr_strb[0]) begin
        top_next.capture_en = wr_data[NPP_CTRL_CAPTURE];
      end
    end
    // Read side
    if (top_reg.rvalid && s_axi_rready) begin
      top_next.rvalid = 1'b0;
    end
    if (ar_hs) begin
      top_next.rvalid = 1'b1;
      top_next.rdata = '0;
      top_next.rresp = npp_mapped(s_axi_araddr) ? NPP_RESP_OKAY :
        NPP_RESP_SLVERR;
      case (s_axi_araddr)
        NPP_OFS_STATUS: top_next.rdata[NPP_EV_W-1:0] = status;
        NPP_OFS_MASK: top_next.rdata[NPP_EV_W-1:0] = mask;
        NPP_OFS_WORD: begin
          // Fields sit at their word positions
          top_next.rdata[15:0] = word_q;
          top_next.rdata[NPP_BIT_RSVD] = 1'b0;
        end
        NPP_OFS_CTRL: top_next.rdata[NPP_CTRL_CAPTURE] =
          top_reg.capture_en;
        NPP_OFS_INFO: begin
          top_next.rdata[NPP_INFO_EXPTOG] = exp_toggle;
          top_next.rdata[NPP_INFO_ACTIVE] = active;
        end
        default: top_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      top_reg <= '{NPP_WS_IDLE, 8'h00, 32'h0000_0000, 4'h0,
        NPP_RESP_OKAY, 1'b0, NPP_RESP_OKAY, 32'h0000_0000,
        NPP_CTRL_RST};
    end else if (ce) begin
      top_reg <= top_next;
    end
  end

  assign s_axi_bresp = top_reg.bresp;
  assign s_axi_rvalid = top_reg.rvalid;
  assign s_axi_rresp = top_reg.rresp;
  assign s_axi_rdata = top_reg.rdata;

  // ==========
  // Checks
  logic cap_take;
  assign cap_take = ce && page_valid && top_reg.capture_en;

  word_reset_a: assert property (
    @(posedge sys_clk) (nrst && !$past(nrst)) |->
      (word_q == NPP_WORD_RST))
    else $error("page word not zero after reset");

  rsvd_zero_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
      (word_q[NPP_BIT_RSVD] == 1'b0) &&
      !(s_axi_rvalid && s_axi_rdata[NPP_BIT_RSVD] &&
        $past(s_axi_araddr) == NPP_OFS_WORD && $rose(s_axi_rvalid)))
    else $error("reserved bit reads as one");

  word_load_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
      cap_take |=> (word_q == ($past(page_word) & NPP_RSVD_KEEP)))
    else $error("page word not loaded whole");

  word_hold_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
      !cap_take |=> $stable(word_q))
    else $error("page word changed without a page");

  first_toggle_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
      (ce && base_valid && !cap_take) |=>
        (exp_toggle == !$past(base_toggle)))
    else $error("first expected toggle wrong");

  next_toggle_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
      cap_take |=> (exp_toggle == !$past(page_word[NPP_BIT_TOG])))
    else $error("expected toggle did not alternate");

  page_status_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
      cap_take ##1 ce |=> status[NPP_EV_PAGE])
    else $error("page received not flagged");

  last_flag_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
      (cap_take && !page_word[NPP_BIT_MORE]) |=>
        events[NPP_EV_LAST] ##1 (!$past(ce) || status[NPP_EV_LAST]))
    else $error("last page not flagged");

  word_read_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
      (ar_hs && s_axi_araddr == NPP_OFS_WORD) |=>
        s_axi_rvalid && (s_axi_rdata[15:0] == $past(word_q)) &&
        (s_axi_rdata[31:16] == 16'h0000) &&
        (s_axi_rresp == NPP_RESP_OKAY))
    else $error("word read returned wrong data");

  field_read_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
      (ar_hs && s_axi_araddr == NPP_OFS_WORD) |=>
        (s_axi_rdata[NPP_BIT_MSG] == $past(word_q[NPP_BIT_MSG])) &&
        (s_axi_rdata[NPP_BIT_ACK] == $past(word_q[NPP_BIT_ACK])))
    else $error("page or comply flag misplaced");

  bad_write_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
      (wr_do && ce && !npp_mapped(wr_addr)) |=>
        s_axi_bvalid && (s_axi_bresp == NPP_RESP_SLVERR))
    else $error("unmapped write not refused");

  // Event path through the sticky status, not the output gate alone
  irq_level_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
      (ce && (|(events & mask)) && !mask_we) |=> irq)
    else $error("unmasked event raised no interrupt");

  irq_source_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
      $rose(irq) |-> $past(ce && (mask_we || (|events))))
    else $error("interrupt rose with no event");

  read_clear_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
      (status_rd && !(|events)) |=> (status == NPP_EV_RST))
    else $error("status not cleared by read");

  toggle_flag_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
      (cap_take && active) |=>
        (events[NPP_EV_TOGGLE] ==
          ($past(page_word[NPP_BIT_TOG]) != $past(exp_toggle))))
    else $error("toggle mismatch not flagged");

  word_write_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
      (wr_do && (wr_addr == NPP_OFS_WORD)) |=>
        s_axi_bvalid && (s_axi_bresp == NPP_RESP_OKAY) &&
        ((word_q == $past(word_q)) || $past(cap_take)))
    else $error("word write not ignored");

  // Freeze covers every register, not only the bus side
  frozen_state_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
      !ce |=> $stable(top_reg) && $stable(word_q) && $stable(status) &&
        $stable(mask) && $stable(exp_toggle) && $stable(active) &&
        $stable(events))
    else $error("state moved while clock enable low");
endmodule : npp_partner_page

// ===== rtl/npp_pkg.sv
// Purpose: constants and types for the partner next-page register block
// Assumes: AXI4-Lite with 32-bit data, 8-bit byte address
// Notes: every offset is a byte address
// ==========
// Types
package npp_pkg;
  typedef logic [7:0] npp_addr_t;
  typedef logic [31:0] npp_data_t;
  typedef logic [15:0] npp_word_t;
  typedef logic [1:0] npp_resp_t;

  // ==========
  // Register map
  localparam npp_addr_t NPP_OFS_STATUS = 8'h00;
  localparam npp_addr_t NPP_OFS_MASK = 8'h04;
  localparam npp_addr_t NPP_OFS_WORD = 8'h08;
  localparam npp_addr_t NPP_OFS_CTRL = 8'h0C;
  localparam npp_addr_t NPP_OFS_INFO = 8'h10;

  // ==========
  // Page word fields
  localparam int unsigned NPP_BIT_MORE = 15;
  localparam int unsigned NPP_BIT_RSVD = 14;
  localparam int unsigned NPP_BIT_MSG = 13;
  localparam int unsigned NPP_BIT_ACK = 12;
  localparam int unsigned NPP_BIT_TOG = 11;
  localparam int unsigned NPP_CODE_HI = 10;
  localparam int unsigned NPP_CODE_LO = 0;
  localparam npp_word_t NPP_WORD_RST = 16'h0000;
  localparam npp_word_t NPP_RSVD_KEEP = 16'hBFFF;

  // ==========
  // Events, mask, control
  localparam int unsigned NPP_EV_W = 3;
  localparam int unsigned NPP_EV_PAGE = 0;
  localparam int unsigned NPP_EV_TOGGLE = 1;
  localparam int unsigned NPP_EV_LAST = 2;
  localparam logic [2:0] NPP_EV_RST = 3'h0;
  localparam logic [2:0] NPP_MASK_RST = 3'h0;
  localparam int unsigned NPP_CTRL_CAPTURE = 0;
  localparam logic NPP_CTRL_RST = 1'h1;
  localparam int unsigned NPP_INFO_EXPTOG = 0;
  localparam int unsigned NPP_INFO_ACTIVE = 1;

  localparam npp_resp_t NPP_RESP_OKAY = 2'h0;
  localparam npp_resp_t NPP_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    NPP_WS_IDLE = 2'b00,
    NPP_WS_HAVE_AW = 2'b01,
    NPP_WS_HAVE_W = 2'b10,
    NPP_WS_RESP = 2'b11
  } npp_wst_e;
endpackage : npp_pkg

// ===== rtl/npp_page_capture.sv
// Purpose: holds the partner next-page word and tracks the toggle
// Assumes: page inputs come from logic on sys_clk
// Notes: event outputs are one-cycle pulses while ce is high, held while ce is low
`timescale 1ns/1ns
module npp_page_capture (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic capture_en,
  input wire logic base_valid,
  input wire logic base_toggle,
  input wire logic page_valid,
  input wire npp_pkg::npp_word_t page_word,
  output npp_pkg::npp_word_t word_q,
  output logic exp_toggle,
  output logic active,
  output logic [npp_pkg::NPP_EV_W-1:0] events
);
  import npp_pkg::*;

  typedef struct packed {
    npp_word_t word;
    logic exp_tog;
    logic active;
    logic [NPP_EV_W-1:0] ev;
  } npp_cap_s;

  npp_cap_s cap_reg;
  npp_cap_s cap_next;

  always_comb begin
    cap_next = cap_reg;
    cap_next.ev = '0;
    if (base_valid) begin
      cap_next.exp_tog = ~base_toggle;
      cap_next.active = 1'b1;
    end
    if (page_valid && capture_en) begin
      // Whole word at once, reserved bit forced low
      cap_next.word = page_word & NPP_RSVD_KEEP;
      cap_next.ev[NPP_EV_PAGE] = 1'b1;
      cap_next.ev[NPP_EV_TOGGLE] = cap_reg.active &&
        (page_word[NPP_BIT_TOG] != cap_reg.exp_tog);
      cap_next.exp_tog = ~page_word[NPP_BIT_TOG];
      cap_next.ev[NPP_EV_LAST] = ~page_word[NPP_BIT_MORE];
      cap_next.active = page_word[NPP_BIT_MORE];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cap_reg <= '{NPP_WORD_RST, 1'b0, 1'b0, NPP_EV_RST};
    end else if (ce) begin
      cap_reg <= cap_next;
    end
  end

  assign word_q = cap_reg.word;
  assign exp_toggle = cap_reg.exp_tog;
  assign active = cap_reg.active;
  assign events = cap_reg.ev;
endmodule : npp_page_capture

// ===== rtl/npp_irq.sv
// Purpose: sticky event status, mask and interrupt level
// Assumes: rd_clr is one cycle, status sampled by the caller that cycle
// Notes: a set in the clearing cycle survives
`timescale 1ns/1ns
module npp_irq (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [npp_pkg::NPP_EV_W-1:0] set_ev,
  input wire logic rd_clr,
  input wire logic mask_we,
  input wire logic [npp_pkg::NPP_EV_W-1:0] mask_wdata,
  output logic [npp_pkg::NPP_EV_W-1:0] status,
  output logic [npp_pkg::NPP_EV_W-1:0] mask,
  output logic irq
);
  import npp_pkg::*;

  typedef struct packed {
    logic [NPP_EV_W-1:0] status;
    logic [NPP_EV_W-1:0] mask;
  } npp_irq_s;

  npp_irq_s irq_reg;
  npp_irq_s irq_next;

  always_comb begin
    irq_next = irq_reg;
    // Set wins over the read clear
    irq_next.status = (rd_clr ? '0 : irq_reg.status) | set_ev;
    if (mask_we) begin
      irq_next.mask = mask_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irq_reg <= '{NPP_EV_RST, NPP_MASK_RST};
    end else if (ce) begin
      irq_reg <= irq_next;
    end
  end

  assign status = irq_reg.status;
  assign mask = irq_reg.mask;
  assign irq = |(irq_reg.status & irq_reg.mask);
endmodule : npp_irq

// ===== verification/npp_link_partner.sv
// Purpose: remote link partner that sends base and next-page words
// Assumes: words are handed over on sys_clk, one cycle each
// Notes: sends the reserved bit as one, the device must drop it
`timescale 1ns/1ns
// ==========
// Link partner
module npp_link_partner (
  input wire logic sys_clk,
  output logic base_valid,
  output logic base_toggle,
  output logic page_valid,
  output npp_pkg::npp_word_t page_word
);
  import npp_pkg::*;
  logic tog;
  initial begin
    base_valid = 1'b0;
    base_toggle = 1'b0;
    page_valid = 1'b0;
    page_word = 16'h0000;
    tog = 1'b0;
  end
  task send_base(input logic t);
    base_valid <= 1'b1;
    base_toggle <= t;
    tog = ~t;
    @(posedge sys_clk);
    #1;
    base_valid <= 1'b0;
    base_toggle <= ~t;
  endtask : send_base
  // Bad flips the toggle of this word only
  task send_page(input logic [2:0] f, input logic [10:0] code,
                 input logic bad, output npp_word_t w);
    w = {f[2], 1'b1, f[1], f[0], tog ^ bad, code};
    tog = ~tog;
    page_valid <= 1'b1;
    page_word <= w;
    @(posedge sys_clk);
    #1;
    page_valid <= 1'b0;
    // Stale data would hide a late capture
    page_word <= ~w;
  endtask : send_page
endmodule : npp_link_partner

// ===== verification/test_next_page_partner_ability_reg.sv
// Purpose: self-checking bench for the partner next-page register
// Assumes: AXI4-Lite master here, partner model on the page side
// Notes: expected reads and responses queue up, a monitor compares
`timescale 1ns/1ns
module test_next_page_partner_ability_reg;
  import npp_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic base_valid, base_toggle, page_valid, irq;
  npp_word_t page_word, wdrop;
  npp_addr_t s_axi_awaddr = 8'h00;
  npp_addr_t s_axi_araddr = 8'h00;
  npp_data_t s_axi_wdata = 32'h00000000;
  npp_data_t s_axi_rdata, lastw;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  npp_resp_t s_axi_bresp, s_axi_rresp;
  npp_data_t qd[$];
  npp_resp_t qr[$];
  npp_resp_t qb[$];
  int bad_count = 0;
  int n_compared = 0;
  logic [15:0] rnd = 16'h0004;

  always #4 sys_clk = ~sys_clk;

  npp_partner_page u_npp_partner_page (.sys_clk(sys_clk), .nrst(nrst),
    .ce(ce), .base_valid(base_valid), .base_toggle(base_toggle),
    .page_valid(page_valid), .page_word(page_word), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  npp_link_partner u_npp_link_partner (.sys_clk(sys_clk),
    .base_valid(base_valid), .base_toggle(base_toggle),
    .page_valid(page_valid), .page_word(page_word));

  // ==========
  // Checks and report
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task chk_d(input npp_data_t g, input npp_data_t e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t got %0h exp %0h", $time, g, e);
    end
  endtask : chk_d
  task chk_r(input npp_resp_t g, input npp_resp_t e);
    chk_d({30'h0, g}, {30'h0, e});
  endtask : chk_r
  task chk_i(input logic e);
    chk_d({31'h0, irq}, {31'h0, e});
  endtask : chk_i
  task lim(inout int k);
    k++;
    if (k > 50) begin
      bad_count++;
      close_out();
    end
  endtask : lim
  task tick;
    @(posedge sys_clk);
    #1;
  endtask : tick

  // Negedge sampling avoids racing the handshake edge
  always @(negedge sys_clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
      chk_d(s_axi_rdata, qd.pop_front());
      chk_r(s_axi_rresp, qr.pop_front());
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready) chk_r(s_axi_bresp,
      qb.pop_front());
  end

  // ==========
  // Bus master
  task rd(input npp_addr_t a, input npp_data_t e, input npp_resp_t r);
    int k;
    k = 0;
    qd.push_back(e);
    qr.push_back(r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    #1;
    while (s_axi_arready !== 1'b1) begin
      tick();
      lim(k);
    end
    tick();
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) begin
      tick();
      lim(k);
    end
    tick();
    s_axi_rready <= 1'b0;
    tick();
  endtask : rd
  task wr(input npp_addr_t a, input npp_data_t d, input npp_resp_t r);
    int k;
    logic aw, w;
    k = 0;
    aw = 1'b1;
    w = 1'b1;
    qb.push_back(r);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    #1;
    while (aw || w) begin
      if (s_axi_awready === 1'b1) aw = 1'b0;
      if (s_axi_wready === 1'b1) w = 1'b0;
      tick();
      if (!aw) s_axi_awvalid <= 1'b0;
      if (!w) s_axi_wvalid <= 1'b0;
      lim(k);
    end
    while (s_axi_bvalid !== 1'b1) begin
      tick();
      lim(k);
    end
    tick();
    s_axi_bready <= 1'b0;
    tick();
  endtask : wr
  task pg(input logic [2:0] f, input logic bad);
    npp_word_t w;
    rnd = lfsr(rnd);
    u_npp_link_partner.send_page(f, rnd[10:0], bad, w);
    repeat (3) tick();
    lastw = {16'h0000, w & NPP_RSVD_KEEP};
    rd(NPP_OFS_WORD, lastw, NPP_RESP_OKAY);
  endtask : pg

  // ==========
  // Scenarios
  initial begin
    repeat (4) tick();
    nrst <= 1'b1;
    tick();
    rd(NPP_OFS_WORD, 32'h0, NPP_RESP_OKAY);
    rd(NPP_OFS_STATUS, 32'h0, NPP_RESP_OKAY);
    rd(NPP_OFS_CTRL, 32'h1, NPP_RESP_OKAY);
    wr(NPP_OFS_WORD, 32'h0000BFFF, NPP_RESP_OKAY);
    rd(NPP_OFS_WORD, 32'h0, NPP_RESP_OKAY);
    wr(8'h14, 32'h1, NPP_RESP_SLVERR);
    rd(8'h14, 32'h0, NPP_RESP_SLVERR);
    $display("test reset and map done");
    u_npp_link_partner.send_base(1'b1);
    for (int i = 0; i < 4; i++) begin
      pg({i != 3, i[0], i[1]}, 1'b0);
      if (i == 0) rd(NPP_OFS_INFO, 32'h3, NPP_RESP_OKAY);
      rd(NPP_OFS_STATUS, (i == 3) ? 5 : 1, NPP_RESP_OKAY);
    end
    $display("test page exchange done");
    u_npp_link_partner.send_base(1'b0);
    pg(3'b100, 1'b1);
    chk_i(1'b0);
    wr(NPP_OFS_MASK, 32'h2, NPP_RESP_OKAY);
    chk_i(1'b1);
    rd(NPP_OFS_STATUS, 32'h3, NPP_RESP_OKAY);
    rd(NPP_OFS_STATUS, 32'h0, NPP_RESP_OKAY);
    chk_i(1'b0);
    $display("test toggle fault and interrupt done");
    wr(NPP_OFS_CTRL, 32'h0, NPP_RESP_OKAY);
    u_npp_link_partner.send_page(3'b111, 11'h7FF, 1'b0, wdrop);
    repeat (3) tick();
    rd(NPP_OFS_WORD, lastw, NPP_RESP_OKAY);
    rd(NPP_OFS_STATUS, 32'h0, NPP_RESP_OKAY);
    wr(NPP_OFS_CTRL, 32'h1, NPP_RESP_OKAY);
    $display("test capture off done");
    // Page offered while frozen must not land
    ce <= 1'b0;
    u_npp_link_partner.send_page(3'b011, 11'h155, 1'b0, wdrop);
    tick();
    ce <= 1'b1;
    tick();
    rd(NPP_OFS_WORD, lastw, NPP_RESP_OKAY);
    rd(NPP_OFS_STATUS, 32'h0, NPP_RESP_OKAY);
    $display("test clock enable done");
    nrst <= 1'b0;
    repeat (2) tick();
    nrst <= 1'b1;
    tick();
    rd(NPP_OFS_WORD, 32'h0, NPP_RESP_OKAY);
    rd(NPP_OFS_MASK, 32'h0, NPP_RESP_OKAY);
    rd(NPP_OFS_INFO, 32'h0, NPP_RESP_OKAY);
    chk_i(1'b0);
    $display("test reset in run done");
    close_out();
  end
endmodule : test_next_page_partner_ability_reg
